// *** pkg/motor_spi_pkg.sv ***
package motor_spi_pkg;
   // Clock and host-side timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int CS_IDLE_NS = 500;
   localparam int CS_IDLE_CYC =
      (CS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Frame layout
   localparam int CNT_W = 11;
   localparam logic [10:0] CNT_MAX = 11'h7FF;
   localparam logic [10:0] CNT_FRAME = 11'h010;
   localparam logic [2:0] BYTE_DONE = 3'h0;
   localparam int POS_RW = 6;
   localparam int ADDR_HI = 5;
   localparam int ADDR_LO = 1;
   localparam int POS_SINGLE = 7;
   localparam logic [1:0] PFX_STATUS = 2'h3;
   localparam logic [1:0] PFX_HEADER = 2'h2;
   localparam int HDR_CLR_POS = 5;
   localparam int CHAIN_HI = 5;
   localparam logic [5:0] CHAIN_SAT = 6'h3F;
   localparam logic [6:0] POST_MAX = 7'h7F;
   // Register map
   localparam logic [4:0] ADDR_FAULT_SUMMARY = 5'h00;
   localparam logic [4:0] ADDR_BRIDGE_OC = 5'h01;
   localparam logic [4:0] ADDR_THERMAL_OL = 5'h02;
   localparam logic [4:0] ADDR_TORQUE_SLEW = 5'h03;
   localparam logic [4:0] ADDR_OUTPUT_DECAY = 5'h04;
   localparam logic [4:0] ADDR_STEP_DIR = 5'h05;
   localparam logic [4:0] ADDR_PROTECTION = 5'h06;
   localparam logic [4:0] ADDR_RSVD_CTRL_A = 5'h07;
   localparam logic [4:0] ADDR_RSVD_CTRL_B = 5'h08;
   localparam logic [4:0] ADDR_RSVD_RO = 5'h09;
   localparam logic [4:0] ADDR_REVISION = 5'h0A;
   localparam int NUM_CTRL = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int FAULT_CLEAR_BIT_POS = 7;
   localparam logic [7:0] FAULT_CLEAR_BIT_MASK = 8'h80;
   typedef enum logic [4:0] {
      PH_PRE = 5'h01,
      PH_SECOND_HEADER_BYTE = 5'h02,
      PH_POST = 5'h04,
      PH_SINGLE = 5'h08,
      PH_BAD = 5'h10
   } phase_t;
endpackage

// *** rtl/motor_spi_slave.sv ***
`timescale 1ns/100ps
module motor_spi_slave
   import motor_spi_pkg::*;
#(
   parameter logic [3:0] REV_ID = 4'h1 // Arbitrary value
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial link
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   // Fault sources
   input wire logic supply_low_flag,
   input wire logic pump_low_flag,
   input wire logic overcurrent_flag,
   input wire logic temperature_flag,
   input wire logic open_load_flag,
   input wire logic [7:0] bridge_overcurrent_detail,
   input wire logic [7:0] thermal_openload_detail,
   // Control outputs
   output logic [7:0] torque_slew_control,
   output logic [7:0] output_decay_control,
   output logic [7:0] step_direction_control,
   output logic [7:0] protection_control,
   output logic [7:0] reserved_control_a,
   output logic [7:0] reserved_control_b,
   output logic fault_clear_pulse,
   output logic fault_pin_n
);

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] cs_s;
      logic [2:0] sdi_s;
      logic sclk_f;
      logic cs_f;
      logic sdi_f;
      phase_t phase;
      logic [10:0] cnt;
      logic [7:0] rx;
      logic [5:0] stat_cnt;
      logic [5:0] chain_len;
      logic [6:0] post_cnt;
      logic clr_req;
      logic addr_ok;
      logic data_ok;
      logic rw;
      logic [4:0] addr;
      logic [7:0] wdata;
      logic [7:0] report;
      logic fwd_rep;
      logic edge_bad;
      logic sdo;
      logic [NUM_CTRL-1:0][7:0] ctrl;
      logic spi_err;
      logic clr_pulse;
      logic fault_n;
   } state_t;

   state_t state_ff;
   state_t nxt_state;
   logic sclk_fall, sclk_rise, cs_fall, cs_rise;
   logic frame_end, frame_good, do_write, do_clear, byte_done;
   logic flag_any;
   logic [7:0] in_byte, status_byte;
   logic [10:0] cnt_inc, chain_bits;
   logic [6:0] slot_a, slot_d;

   assign flag_any = supply_low_flag | pump_low_flag | overcurrent_flag |
                     temperature_flag | open_load_flag;
   assign status_byte = {PFX_STATUS, supply_low_flag, pump_low_flag,
                         overcurrent_flag, 1'b0, temperature_flag,
                         open_load_flag};

   function automatic logic [7:0] reg_read(input logic [4:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_FAULT_SUMMARY: v = {~state_ff.fault_n, state_ff.spi_err,
                                  status_byte[5:0]};
         ADDR_BRIDGE_OC: v = bridge_overcurrent_detail;
         ADDR_THERMAL_OL: v = thermal_openload_detail;
         ADDR_REVISION: v = {4'h0, REV_ID};
         default: begin
            if (a >= ADDR_TORQUE_SLEW && a <= ADDR_RSVD_CTRL_B) begin
               v = state_ff.ctrl[a - ADDR_TORQUE_SLEW];
            end
         end
      endcase
      return v;
   endfunction

   always_comb begin
      nxt_state = state_ff;
      nxt_state.clr_pulse = 1'b0;
      frame_end = 1'b0;
      frame_good = 1'b0;
      do_write = 1'b0;
      do_clear = 1'b0;
      in_byte = {state_ff.rx[6:0], state_ff.sdi_f};
      // Three-stage sampling; a level counts once stages two and three agree
      nxt_state.sclk_s = {state_ff.sclk_s[1:0], sclk};
      nxt_state.cs_s = {state_ff.cs_s[1:0], chip_select_n};
      nxt_state.sdi_s = {state_ff.sdi_s[1:0], sdi};
      if (state_ff.sclk_s[1] == state_ff.sclk_s[2]) begin
         nxt_state.sclk_f = state_ff.sclk_s[2];
      end
      if (state_ff.cs_s[1] == state_ff.cs_s[2]) begin
         nxt_state.cs_f = state_ff.cs_s[2];
      end
      if (state_ff.sdi_s[1] == state_ff.sdi_s[2]) begin
         nxt_state.sdi_f = state_ff.sdi_s[2];
      end
      sclk_fall = state_ff.sclk_f & ~nxt_state.sclk_f;
      sclk_rise = ~state_ff.sclk_f & nxt_state.sclk_f;
      cs_fall = state_ff.cs_f & ~nxt_state.cs_f;
      cs_rise = ~state_ff.cs_f & nxt_state.cs_f;
      if (state_ff.cnt != CNT_MAX) begin
         cnt_inc = state_ff.cnt + 11'h001;
      end else begin
         cnt_inc = CNT_MAX;
      end
      byte_done = sclk_fall & ~state_ff.cs_f &
                  (state_ff.cnt != CNT_MAX) &
                  (cnt_inc[2:0] == BYTE_DONE);
      // Own address slot counts back from the farthest device
      slot_a = {1'b0, state_ff.chain_len} - 7'h01 -
               {1'b0, state_ff.stat_cnt};
      slot_d = {state_ff.chain_len, 1'b0} - 7'h01 -
               {1'b0, state_ff.stat_cnt};
      chain_bits = {({1'b0, state_ff.chain_len} + 7'h01), 4'h0};

      if (cs_fall) begin
         nxt_state.phase = PH_PRE;
         nxt_state.cnt = '0;
         nxt_state.stat_cnt = '0;
         nxt_state.chain_len = '0;
         nxt_state.post_cnt = '0;
         nxt_state.clr_req = 1'b0;
         nxt_state.addr_ok = 1'b0;
         nxt_state.data_ok = 1'b0;
         nxt_state.fwd_rep = 1'b0;
         nxt_state.edge_bad = state_ff.sclk_f;
         nxt_state.sdo = status_byte[7];
      end else if (!state_ff.cs_f) begin
         if (sclk_fall) begin
            nxt_state.rx = in_byte;
            nxt_state.cnt = cnt_inc;
         end
         if (sclk_rise) begin
            // Bits past the first byte lag the input by one byte, except the byte after the own address byte, which carries the report
            if (state_ff.cnt < CNT_FRAME >> 1) begin
               nxt_state.sdo = status_byte[~state_ff.cnt[2:0]];
            end else if (state_ff.fwd_rep) begin
               nxt_state.sdo = state_ff.report[~state_ff.cnt[2:0]];
            end else begin
               nxt_state.sdo = state_ff.rx[7];
            end
         end
      end

      if (byte_done) begin
         nxt_state.fwd_rep = 1'b0;
         unique case (state_ff.phase)
            PH_PRE: begin
               if (!in_byte[POS_SINGLE]) begin
                  nxt_state.phase = PH_SINGLE;
                  nxt_state.rw = in_byte[POS_RW];
                  nxt_state.addr = in_byte[ADDR_HI:ADDR_LO];
                  nxt_state.addr_ok = 1'b1;
                  nxt_state.fwd_rep = 1'b1;
                  nxt_state.report =
                     reg_read(in_byte[ADDR_HI:ADDR_LO]);
               end else if (in_byte[7:6] == PFX_STATUS) begin
                  if (state_ff.stat_cnt == CHAIN_SAT) begin
                     nxt_state.phase = PH_BAD;
                  end else begin
                     nxt_state.stat_cnt = state_ff.stat_cnt + 6'h01;
                  end
               end else begin
                  nxt_state.chain_len = in_byte[CHAIN_HI:0];
                  nxt_state.phase = PH_SECOND_HEADER_BYTE;
               end
            end
            PH_SECOND_HEADER_BYTE: begin
               if (in_byte[7:6] != PFX_HEADER) begin
                  nxt_state.phase = PH_BAD;
               end else begin
                  nxt_state.clr_req = in_byte[HDR_CLR_POS];
                  nxt_state.phase = PH_POST;
               end
            end
            PH_POST: begin
               if (state_ff.post_cnt == slot_a) begin
                  nxt_state.rw = in_byte[POS_RW];
                  nxt_state.addr = in_byte[ADDR_HI:ADDR_LO];
                  nxt_state.addr_ok = 1'b1;
                  nxt_state.fwd_rep = 1'b1;
                  nxt_state.report =
                     reg_read(in_byte[ADDR_HI:ADDR_LO]);
               end
               if (state_ff.post_cnt == slot_d) begin
                  nxt_state.wdata = in_byte;
                  nxt_state.data_ok = 1'b1;
               end
               if (state_ff.post_cnt != POST_MAX) begin
                  nxt_state.post_cnt = state_ff.post_cnt + 7'h01;
               end
            end
            PH_SINGLE: begin
               if (state_ff.cnt == CNT_FRAME - 11'h001) begin
                  nxt_state.wdata = in_byte;
                  nxt_state.data_ok = 1'b1;
               end
            end
            PH_BAD: begin
               nxt_state.phase = PH_BAD;
            end
         endcase
      end

      if (cs_rise) begin
         frame_end = 1'b1;
         if (!state_ff.edge_bad && !state_ff.sclk_f) begin
            if (state_ff.phase == PH_SINGLE) begin
               frame_good = state_ff.data_ok &
                            (state_ff.cnt == CNT_FRAME);
            end else if (state_ff.phase == PH_POST) begin
               frame_good = (state_ff.chain_len != 6'h00) &
                            (state_ff.stat_cnt < state_ff.chain_len) &
                            state_ff.addr_ok & state_ff.data_ok &
                            (state_ff.cnt == chain_bits);
            end
         end
         do_write = frame_good & ~state_ff.rw;
         do_clear = frame_good & ((state_ff.phase == PH_POST &
                    state_ff.clr_req) | (do_write &
                    (state_ff.addr == ADDR_PROTECTION) &
                    state_ff.wdata[FAULT_CLEAR_BIT_POS]));
      end

      // Read-only and unlisted locations silently keep their contents
      if (do_write && state_ff.addr >= ADDR_TORQUE_SLEW &&
          state_ff.addr <= ADDR_RSVD_CTRL_B) begin
         if (state_ff.addr == ADDR_PROTECTION) begin
            nxt_state.ctrl[state_ff.addr - ADDR_TORQUE_SLEW] =
               state_ff.wdata & ~FAULT_CLEAR_BIT_MASK;
         end else begin
            nxt_state.ctrl[state_ff.addr - ADDR_TORQUE_SLEW] =
               state_ff.wdata;
         end
      end

      // Error set outranks a clear landing on the same edge
      if (frame_end && !frame_good) begin
         nxt_state.spi_err = 1'b1;
      end else if (do_clear) begin
         nxt_state.spi_err = 1'b0;
      end
      nxt_state.clr_pulse = do_clear;
      nxt_state.fault_n = ~(nxt_state.spi_err | flag_any);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= '0;
         state_ff.cs_s <= 3'h7;
         state_ff.cs_f <= 1'b1;
         state_ff.phase <= PH_PRE;
         state_ff.ctrl <= {NUM_CTRL{CTRL_RESET}};
         state_ff.fault_n <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign sdo = state_ff.sdo;
   assign sdo_oe = ~state_ff.cs_f;
   assign torque_slew_control = state_ff.ctrl[ADDR_TORQUE_SLEW -
                                              ADDR_TORQUE_SLEW];
   assign output_decay_control = state_ff.ctrl[ADDR_OUTPUT_DECAY -
                                               ADDR_TORQUE_SLEW];
   assign step_direction_control = state_ff.ctrl[ADDR_STEP_DIR -
                                                 ADDR_TORQUE_SLEW];
   assign protection_control = state_ff.ctrl[ADDR_PROTECTION -
                                             ADDR_TORQUE_SLEW];
   assign reserved_control_a = state_ff.ctrl[ADDR_RSVD_CTRL_A -
                                             ADDR_TORQUE_SLEW];
   assign reserved_control_b = state_ff.ctrl[ADDR_RSVD_CTRL_B -
                                             ADDR_TORQUE_SLEW];
   assign fault_clear_pulse = state_ff.clr_pulse;
   assign fault_pin_n = state_ff.fault_n;

   a_sdo_released: assert property (@(posedge clk) disable iff (!rst_b)
      cs_rise |=> !sdo_oe [*3])
      else $error("data out driven while deselected");
   a_status_lead: assert property (@(posedge clk) disable iff (!rst_b)
      cs_fall |=> sdo)
      else $error("status byte does not start with one");
   a_status_two: assert property (@(posedge clk) disable iff (!rst_b)
      (sclk_rise && !state_ff.cs_f && state_ff.cnt == 11'h001) |=> sdo)
      else $error("second status bit not one");
   a_bad_sets_err: assert property (@(posedge clk) disable iff (!rst_b)
      (frame_end && !frame_good) |=> state_ff.spi_err && !fault_pin_n)
      else $error("bad frame did not raise error");
   a_bad_no_write: assert property (@(posedge clk) disable iff (!rst_b)
      (frame_end && !frame_good) |=> $stable(state_ff.ctrl))
      else $error("bad frame changed a register");
   a_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
      (do_write && state_ff.addr == ADDR_OUTPUT_DECAY)
      |=> output_decay_control == $past(state_ff.wdata))
      else $error("write data not stored");
   a_report_rev: assert property (@(posedge clk) disable iff (!rst_b)
      ($rose(state_ff.addr_ok) && state_ff.addr == ADDR_REVISION)
      |-> state_ff.report == {4'h0, REV_ID})
      else $error("report does not match register");
   a_fault_pin: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff.spi_err |-> !fault_pin_n)
      else $error("fault pin high during error");
   a_chain_clear: assert property (@(posedge clk) disable iff (!rst_b)
      (frame_good && state_ff.phase == PH_POST && state_ff.clr_req)
      |=> fault_clear_pulse && !state_ff.spi_err ##1 !fault_clear_pulse)
      else $error("chain clear not applied");
   a_single_len: assert property (@(posedge clk) disable iff (!rst_b)
      (frame_end && state_ff.phase == PH_SINGLE &&
       state_ff.cnt != CNT_FRAME) |-> !frame_good)
      else $error("odd length frame accepted");

endmodule // motor_spi_slave

// *** sim/motor_driver_spi_daisy_chain_test.sv ***
`timescale 1ns/100ps
module motor_driver_spi_daisy_chain_test;
   import motor_spi_pkg::*;
   localparam logic [3:0] REV_SET = 4'h6; // Arbitrary value
   logic clk, rst_b, sclk, chip_select_n, sdi, sdo, sdo_oe;
   logic fault_clear_pulse, fault_pin_n, clr_seen;
   logic [4:0] flg;
   logic [7:0] det_a, det_b;
   logic [NUM_CTRL-1:0][7:0] ctl;
   logic [63:0] rx;
   int err_total = 0;
   int samples_checked = 0;

   motor_spi_slave #(.REV_ID(REV_SET)) u_motor_spi_slave (
      .clk(clk), .rst_b(rst_b), .sclk(sclk), .chip_select_n(chip_select_n),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
      .supply_low_flag(flg[4]), .pump_low_flag(flg[3]),
      .overcurrent_flag(flg[2]), .temperature_flag(flg[1]),
      .open_load_flag(flg[0]), .bridge_overcurrent_detail(det_a),
      .thermal_openload_detail(det_b), .torque_slew_control(ctl[0]),
      .output_decay_control(ctl[1]), .step_direction_control(ctl[2]),
      .protection_control(ctl[3]), .reserved_control_a(ctl[4]),
      .reserved_control_b(ctl[5]), .fault_clear_pulse(fault_clear_pulse),
      .fault_pin_n(fault_pin_n));
   spi_host_model u_spi_host_model (.sclk(sclk),
      .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (fault_clear_pulse === 1'b1) begin
         clr_seen = 1'b1;
      end
   end

   function automatic logic [7:0] st();
      return {2'b11, flg[4:2], 1'b0, flg[1:0]};
   endfunction
   task automatic chk_reply(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t reply %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic rw, input logic [4:0] a,
                       input logic [7:0] d, input logic [7:0] exp);
      logic [63:0] r;
      u_spi_host_model.frame(16, {48'h0, 1'b0, rw, a, 1'b0, d}, r);
      chk_reply(r, {48'h0, st(), exp});
      chk_val({7'h0, sdo_oe}, 8'h00);
   endtask
   task automatic finish_test();
      $display("Mismatches %0d, checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      #2_000_000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      rst_b = 1'b0;
      flg = '0;
      det_a = 8'h96;
      det_b = 8'h2D;
      clr_seen = 1'b0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      chk_val({7'h0, sdo_oe}, 8'h00);
      chk_val({7'h0, fault_pin_n}, 8'h01);
      for (int i = 0; i < NUM_CTRL; i++) begin
         xfer(1'b0, ADDR_TORQUE_SLEW + 5'(i), 8'(8'h11 * (i + 1)), 8'h00);
      end
      for (int i = 0; i < NUM_CTRL; i++) begin
         xfer(1'b1, ADDR_TORQUE_SLEW + 5'(i), 8'h00, 8'(8'h11 * (i + 1)));
         chk_val(ctl[i], 8'(8'h11 * (i + 1)));
      end
      xfer(1'b0, ADDR_OUTPUT_DECAY, 8'h5A, 8'h22);
      xfer(1'b1, ADDR_OUTPUT_DECAY, 8'h00, 8'h5A);
      // Read-only and unmapped places ignore writes
      xfer(1'b0, ADDR_RSVD_RO, 8'hFF, 8'h00);
      xfer(1'b1, ADDR_RSVD_RO, 8'h00, 8'h00);
      xfer(1'b0, 5'h1F, 8'h00, 8'h00);
      xfer(1'b1, 5'h1F, 8'h00, 8'h00);
      xfer(1'b0, ADDR_BRIDGE_OC, 8'hFF, det_a);
      xfer(1'b1, ADDR_BRIDGE_OC, 8'h00, det_a);
      xfer(1'b1, ADDR_THERMAL_OL, 8'h00, det_b);
      xfer(1'b1, ADDR_REVISION, 8'h00, {4'h0, REV_SET});
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         flg = 5'(1 << i);
         xfer(1'b1, ADDR_FAULT_SUMMARY, 8'h00,
              {2'b10, flg[4:2], 1'b0, flg[1:0]});
         chk_val({7'h0, fault_pin_n}, 8'h00);
      end
      @(negedge clk);
      flg = '0;
      // Short and long frames are discarded and latch the error
      u_spi_host_model.frame(15, {49'h0, 2'b00, ADDR_TORQUE_SLEW, 8'h77}, rx);
      chk_val({7'h0, fault_pin_n}, 8'h00);
      xfer(1'b1, ADDR_FAULT_SUMMARY, 8'h00, 8'hC0);
      u_spi_host_model.frame(17,
         {47'h0, 2'b00, ADDR_TORQUE_SLEW, 1'b0, 8'hEE, 1'b0}, rx);
      chk_val(ctl[0], 8'h11);
      clr_seen = 1'b0;
      xfer(1'b0, ADDR_PROTECTION, 8'h85, 8'h44);
      chk_val({6'h0, clr_seen, fault_pin_n}, 8'h03);
      chk_val(ctl[3], 8'h05);
      xfer(1'b1, ADDR_FAULT_SUMMARY, 8'h00, 8'h00);
      // Chain of one with the header clear bit
      u_spi_host_model.frame(17, 64'h0, rx);
      clr_seen = 1'b0;
      u_spi_host_model.frame(32, {32'h0, 8'h81, 8'hB5, 2'b01, ADDR_STEP_DIR,
         1'b0, 8'h00}, rx);
      chk_reply(rx, {32'h0, st(), 8'h81, 8'hB5, 8'h33});
      chk_val({6'h0, clr_seen, fault_pin_n}, 8'h03);
      // Second of two: one status byte ahead of the headers
      u_spi_host_model.frame(48, {16'h0, 8'hC0, 8'h82, 8'h95, 8'h0E, 8'h3C,
         8'hA5}, rx);
      chk_reply(rx, {16'h0, st(), 8'hC0, 8'h82, 8'h95, 8'h55, 8'h3C});
      chk_val(ctl[4], 8'hA5);
      finish_test();
   end
endmodule // motor_driver_spi_daisy_chain_test

// *** sim/spi_host_model.sv ***
`timescale 1ns/100ps
module spi_host_model (
   // Serial link
   output logic sclk,
   output logic chip_select_n,
   output logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   logic last_b;
   logic miso;
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      sdi = 1'b0;
      last_b = 1'b0;
   end
   // No pull on the line: a released output reads as the inverse bit
   always @(sdo or sdo_oe) begin
      if (sdo_oe === 1'b1) begin
         last_b = sdo;
      end
   end
   assign miso = (sdo_oe === 1'b1) ? sdo : ~last_b;
   // Link clock only runs inside frames, 400 ns period
   task automatic frame(input int nb, input logic [63:0] tx,
                        output logic [63:0] rx);
      rx = '0;
      chip_select_n = 1'b0; // Clock low at select fall
      #400;
      for (int i = nb - 1; i >= 0; i--) begin
         sclk = 1'b1;
         sdi = tx[i]; // MSB first, change on rise
         #200;
         sclk = 1'b0;
         #190;
         // Late in the low phase, as the device output lags its filter
         rx = {rx[62:0], miso};
         #10;
      end
      chip_select_n = 1'b1; // Clock low at select rise
      sdi = ~sdi;
      #600; // Select idle between frames
   endtask
endmodule // spi_host_model
